/* File: fcd_cmd_buf.sv */
// Two-entry command buffer with valid/ready on both sides
`default_nettype none

module fcd_cmd_buf
    import fcd_pkg::*;
#(
    parameter int W     = CMD_W,         // Entry width
    parameter int DEPTH = BUF_D          // Entry count, power of two
) (
    input  wire logic         i_clk,
    input  wire logic         i_sys_rst,
    input  wire logic         i_in_valid,
    output logic              o_in_ready,
    input  wire logic [W-1:0] i_in_data,
    output logic              o_out_valid,
    input  wire logic         i_out_ready,
    output logic [W-1:0]      o_out_data
);

    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] mem;    // Entry storage
        logic [AW-1:0]           wp;     // Write index
        logic [AW-1:0]           rp;     // Read index
        logic [AW:0]             cnt;    // Fill level
    } fcd_buf_t;

    fcd_buf_t s_r;
    fcd_buf_t s_nxt;
    logic     wr;
    logic     rd;

    // ==========================================
    // Handshakes; full and empty come from the fill level
    assign o_in_ready  = (s_r.cnt != (AW+1)'(DEPTH));
    assign o_out_valid = (s_r.cnt != '0);
    assign o_out_data  = s_r.mem[s_r.rp];
    assign wr          = i_in_valid && o_in_ready;
    assign rd          = o_out_valid && i_out_ready;

    // Next state; pointers wrap because depth is a power of two
    always_comb begin
        s_nxt = s_r;
        if (wr) begin
            s_nxt.mem[s_r.wp] = i_in_data;
            s_nxt.wp          = s_r.wp + 1'b1;
        end
        if (rd) begin
            s_nxt.rp = s_r.rp + 1'b1;
        end
        s_nxt.cnt = s_r.cnt + (AW+1)'(wr) - (AW+1)'(rd);
    end

    // State register
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    // ==========================================
    // Checks
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_sys_rst);

    buf_no_overrun_a: assert property (s_r.cnt <= (AW+1)'(DEPTH))
        else $error("buffer fill level above depth");
    buf_full_c: cover property (!o_in_ready ##1 rd);

endmodule : fcd_cmd_buf

`default_nettype wire

/* File: fcd_periph.sv */
// Peripheral request model facing the transfer controller
`default_nettype none

module fcd_periph
    import fcd_pkg::*;
(
    input  wire logic           i_clk,
    input  wire logic           i_sys_rst,
    input  wire logic [NCH-1:0] i_want,  // Item ready, one source per channel
    input  wire logic [NCH-1:0] i_ack,
    output logic      [NCH-1:0] o_req
);
    // ==========================================
    // Request level per channel
    // Raise only while ack is low, so a stale ack is never taken as ours
    always_ff @(posedge i_clk) begin
        for (int c = 0; c < NCH; c++) begin
            if (i_sys_rst) begin
                o_req[c] <= 1'b0;
            end else if (o_req[c] && i_ack[c]) begin
                o_req[c] <= 1'b0;
            end else if (i_want[c] && !i_ack[c]) begin
                o_req[c] <= 1'b1;
            end
        end
    end
endmodule : fcd_periph

`default_nettype wire

/* File: fcd_pkg.sv */
// Package: constants and types for the five-channel transfer controller
`default_nettype none

package fcd_pkg;

    // ==========================================
    // Geometry
    localparam int NCH   = 5;            // Channel count
    localparam int CMD_W = 72;           // Command word width
    localparam int BUF_D = 2;            // Command buffer depth
    localparam int NRMP  = 2;            // Remappable request sources

    // ==========================================
    // Register byte offsets
    localparam logic [7:0] OFS_FLAGS  = 8'h00;
    localparam logic [7:0] OFS_CLEAR  = 8'h04;
    localparam logic [7:0] OFS_CTL0   = 8'h08;
    localparam logic [7:0] OFS_CNT0   = 8'h0c;
    localparam logic [7:0] OFS_PADDR0 = 8'h10;
    localparam logic [7:0] OFS_MADDR0 = 8'h14;
    localparam logic [7:0] CH_STRIDE  = 8'h14;

    // ==========================================
    // Control field positions
    localparam int CTL_EN   = 0;         // Channel enable
    localparam int CTL_DIR  = 4;         // 1: memory to peripheral
    localparam int CTL_CIRC = 5;         // Circular mode
    localparam int CTL_PINC = 6;         // Peripheral address increment
    localparam int CTL_MINC = 7;         // Memory address increment
    localparam int CTL_PW   = 8;         // Peripheral width, 2 bits
    localparam int CTL_MW   = 10;        // Memory width, 2 bits
    localparam int CTL_CHANNEL_PRIORITY_LEVEL = 12;        // Priority level, 2 bits
    localparam int CTL_M2M  = 14;        // Memory to memory
    localparam logic [31:0] CTL_RW_MASK   = 32'h0000_7fff;
    localparam logic [31:0] CTL_LIVE_MASK = 32'h0000_000f;

    // ==========================================
    // Flag positions inside a channel nibble
    localparam int FLG_G = 0;            // Summary
    localparam int FLG_F = 1;            // Full finish
    localparam int FLG_H = 2;            // Half finish
    localparam int FLG_E = 3;            // Transfer error

    // ==========================================
    // Reset values
    localparam logic [31:0] RST_WORD = 32'h0000_0000;

    // Remap targets of the remappable sources
    localparam int RMP_DFLT[NRMP] = '{0, 1};
    localparam int RMP_ALT[NRMP]  = '{1, 2};

    typedef enum logic [1:0] {
        CHANNEL_PRIORITY_LEVEL_LOW = 2'h0, CHANNEL_PRIORITY_LEVEL_MED = 2'h1, CHANNEL_PRIORITY_LEVEL_HIGH = 2'h2, CHANNEL_PRIORITY_LEVEL_ULTRA = 2'h3
    } fcd_channel_priority_level_t;

    typedef enum logic [1:0] {
        WID_8 = 2'h0, WID_16 = 2'h1, WID_32 = 2'h2
    } fcd_width_t;

    // Per-channel handshake state, Gray along idle-issued-ack
    typedef enum logic [1:0] {
        CH_IDLE = 2'h0, CH_ISSUED = 2'h1, CH_ACK = 2'h3
    } fcd_chst_t;

    // Address step for a width code; reserved code steps by one
    function automatic logic [31:0] fcd_step(input logic [1:0] w);
        case (w)
            WID_16:  return 32'h0000_0002;
            WID_32:  return 32'h0000_0004;
            default: return 32'h0000_0001;
        endcase
    endfunction : fcd_step

endpackage : fcd_pkg

`default_nettype wire

/* File: fcd_top.sv */
// Control logic of the five-channel transfer controller
//
// Function
// R01 - Peripheral raises request when one item ready
// R02 - Acknowledge follows issue of the bus command
// R03 - Request held until ack; ack dropped afterwards
// R04 - Arbiter picks highest software priority first
// R05 - Priority codes: low, medium, high, ultra
// R06 - Equal priority: lower channel number wins
// R07 - Fixed addressing always uses base address
// R08 - Increment steps by 1, 2, 4 per width
// R09 - Width codes 8, 16, 32 bit; one reserved
// R10 - Circular: reload count, set full flag
// R11 - Circular channel serves until enable cleared
// R12 - Memory mode starts unrequested, ends at zero
// R13 - Count drops per transfer; zero issues nothing
// R14 - Software disables channel before reconfiguring
// R15 - Software sets enable bit last
// R16 - Per-channel interrupt with three event sources
// R17 - Interrupt when enabled event flag set
// R18 - Half flag after half the transfers
// R19 - Flag nibble per channel, upper bits reserved
// R20 - Summary flag set when any event flag
// R21 - Writing one clears a flag, zero nothing
// R22 - Summary clear wipes all channel flags
// R23 - Requests on a channel are ORed
// R24 - Only one request source enabled per channel
// R25 - Remap bit moves certain requests elsewhere
// R26 - Control register at 0x08 plus 0x14 each
// R27 - Locked configuration fields while channel enabled
`default_nettype none

module fcd_top
    import fcd_pkg::*;
(
    input  wire logic            i_clk,
    input  wire logic            i_sys_rst,
    // Register port
    input  wire logic [7:0]      i_reg_addr,
    input  wire logic            i_reg_wr_en,
    input  wire logic [31:0]     i_reg_wdata,
    input  wire logic            i_reg_rd_en,
    output logic [31:0]          o_reg_rdata,
    // Peripheral requests and acknowledges
    input  wire logic [NCH-1:0]  i_req_fixed,
    input  wire logic [NRMP-1:0] i_req_remap,
    input  wire logic [NRMP-1:0] i_system_remap_config,
    output logic [NCH-1:0]       o_ack,
    // Command to the bus master datapath
    output logic                 o_cmd_valid,
    input  wire logic            i_cmd_ready,
    output logic [2:0]           o_cmd_chan,
    output logic                 o_cmd_dir,
    output logic [1:0]           o_cmd_peripheral_data_width,
    output logic [1:0]           o_cmd_memory_data_width,
    output logic [31:0]          o_cmd_paddr,
    output logic [31:0]          o_cmd_maddr,
    // Bus error report from the datapath
    input  wire logic            i_xfer_err,
    input  wire logic [2:0]      i_xfer_err_chan,
    // Per-channel interrupts
    output logic [NCH-1:0]       o_irq
);

    // ==========================================
    // State
    typedef struct packed {
        logic [NCH-1:0][31:0] ctl;       // Channel control
        logic [NCH-1:0][15:0] cnt;       // Remaining transfers
        logic [NCH-1:0][15:0] reload;    // Programmed count
        logic [NCH-1:0][31:0] pbase;     // Peripheral base
        logic [NCH-1:0][31:0] mbase;     // Memory base
        logic [NCH-1:0][31:0] pcur;      // Peripheral current
        logic [NCH-1:0][31:0] mcur;      // Memory current
        logic [NCH-1:0][3:0]  flg;       // Event flags
        fcd_chst_t [NCH-1:0]  st;        // Handshake state
        logic [31:0]          rdata;     // Read data
    } fcd_state_t;

    fcd_state_t      s_r;
    fcd_state_t      s_nxt;
    logic [NCH-1:0]  req_ch;             // Combined requests
    logic [NCH-1:0]  elig;               // Ready to be served
    logic            found;              // Some channel eligible
    logic [2:0]      win_ch;             // Arbiter winner
    logic [1:0]      win_channel_priority_level;           // Winner priority
    logic            push;               // Command enters buffer
    logic            buf_in_ready;       // Buffer has room
    logic [CMD_W-1:0] push_data;         // Command word
    logic [CMD_W-1:0] out_data;          // Buffer head
    logic            out_fire;           // Command leaves buffer

    // Register hit at a per-channel offset
    function automatic logic at(input logic [7:0] base, input int c);
        return i_reg_addr == 8'(base + 8'(c) * CH_STRIDE);
    endfunction : at

    // ==========================================
    // Request mapping and arbitration
    always_comb begin
        req_ch   = i_req_fixed;
        found    = 1'b0;
        win_ch   = 3'h0;
        win_channel_priority_level = CHANNEL_PRIORITY_LEVEL_LOW;
        for (int j = 0; j < NRMP; j++) begin
            // Source lands on default or alternate channel
            if (i_system_remap_config[j]) begin                  // R25
                req_ch[RMP_ALT[j]] = req_ch[RMP_ALT[j]] | i_req_remap[j];     // R23
            end else begin
                req_ch[RMP_DFLT[j]] = req_ch[RMP_DFLT[j]] | i_req_remap[j];   // R23
            end
        end
        for (int c = 0; c < NCH; c++) begin
            // Memory mode needs no request; zero count issues nothing
            elig[c] = (s_r.st[c] == CH_IDLE) && s_r.ctl[c][CTL_EN] // R13
                && (s_r.cnt[c] != 16'h0)
                && (s_r.ctl[c][CTL_M2M] || req_ch[c]);             // R12
            // Strictly higher wins, so ties keep the lower number
            if (elig[c] && (!found || s_r.ctl[c][CTL_CHANNEL_PRIORITY_LEVEL +: 2] > win_channel_priority_level)) begin // R04 R05 R06
                found    = 1'b1;
                win_ch   = 3'(c);
                win_channel_priority_level = s_r.ctl[c][CTL_CHANNEL_PRIORITY_LEVEL +: 2];
            end
        end
    end

    // Buffer room stalls the arbiter, so no command is dropped
    assign push      = found && buf_in_ready;
    assign push_data = {win_ch,
                        s_r.ctl[win_ch][CTL_DIR],
                        s_r.ctl[win_ch][CTL_PW +: 2],
                        s_r.ctl[win_ch][CTL_MW +: 2],
                        s_r.pcur[win_ch],
                        s_r.mcur[win_ch]};

    fcd_cmd_buf #(
        .W     (CMD_W),
        .DEPTH (BUF_D)
    ) u_buf (
        .i_clk       (i_clk),
        .i_sys_rst   (i_sys_rst),
        .i_in_valid  (push),
        .o_in_ready  (buf_in_ready),
        .i_in_data   (push_data),
        .o_out_valid (o_cmd_valid),
        .i_out_ready (i_cmd_ready),
        .o_out_data  (out_data)
    );

    assign {o_cmd_chan, o_cmd_dir, o_cmd_peripheral_data_width, o_cmd_memory_data_width,
            o_cmd_paddr, o_cmd_maddr} = out_data;
    assign out_fire = o_cmd_valid && i_cmd_ready;

    // ==========================================
    // Next state: registers, counting, flags, handshake
    always_comb begin
        logic        hit;
        logic [15:0] nc;
        logic [3:0]  clr4;
        logic [3:0]  fl;
        logic        ev_f;
        logic        ev_h;
        logic        ev_e;
        hit   = 1'b0;
        nc    = 16'h0;
        clr4  = 4'h0;
        fl    = 4'h0;
        ev_f  = 1'b0;
        ev_h  = 1'b0;
        ev_e  = 1'b0;
        s_nxt = s_r;
        // Read mux; unmapped and write-only words read zero
        if (i_reg_rd_en) begin
            s_nxt.rdata = RST_WORD;
            if (i_reg_addr == OFS_FLAGS) begin
                s_nxt.rdata = {12'h0, s_r.flg};                   // R19
            end
            for (int c = 0; c < NCH; c++) begin
                if (at(OFS_CTL0, c)) begin                        // R26
                    s_nxt.rdata = s_r.ctl[c];
                end
                if (at(OFS_CNT0, c)) begin
                    s_nxt.rdata = {16'h0, s_r.cnt[c]};
                end
                if (at(OFS_PADDR0, c)) begin
                    s_nxt.rdata = s_r.pbase[c];
                end
                if (at(OFS_MADDR0, c)) begin
                    s_nxt.rdata = s_r.mbase[c];
                end
            end
        end
        for (int c = 0; c < NCH; c++) begin
            hit  = push && (win_ch == 3'(c));
            ev_f = 1'b0;
            ev_h = 1'b0;
            ev_e = 1'b0;
            // Control write; locked fields hold while enabled
            if (i_reg_wr_en && at(OFS_CTL0, c)) begin             // R26
                if (s_r.ctl[c][CTL_EN]) begin
                    s_nxt.ctl[c] = (s_r.ctl[c] & ~CTL_LIVE_MASK)
                        | (i_reg_wdata & CTL_LIVE_MASK);            // R27
                end else begin
                    s_nxt.ctl[c] = i_reg_wdata & CTL_RW_MASK;
                end
            end
            // Count and addresses accept writes only when disabled
            if (i_reg_wr_en && !s_r.ctl[c][CTL_EN]) begin
                if (at(OFS_CNT0, c)) begin
                    s_nxt.cnt[c]    = i_reg_wdata[15:0];
                    s_nxt.reload[c] = i_reg_wdata[15:0];
                end
                // An address write also restarts that current address
                if (at(OFS_PADDR0, c)) begin
                    s_nxt.pbase[c] = i_reg_wdata;
                    s_nxt.pcur[c]  = i_reg_wdata;
                end
                if (at(OFS_MADDR0, c)) begin
                    s_nxt.mbase[c] = i_reg_wdata;
                    s_nxt.mcur[c]  = i_reg_wdata;
                end
            end
            // One transfer issued: count down and step addresses
            if (hit) begin
                nc           = s_r.cnt[c] - 16'h1;                // R13
                s_nxt.cnt[c] = nc;
                // Fixed mode always reuses the base
                s_nxt.pcur[c] = s_r.ctl[c][CTL_PINC]
                    ? s_r.pcur[c] + fcd_step(s_r.ctl[c][CTL_PW +: 2]) // R08 R09
                    : s_r.pbase[c];                                // R07
                s_nxt.mcur[c] = s_r.ctl[c][CTL_MINC]
                    ? s_r.mcur[c] + fcd_step(s_r.ctl[c][CTL_MW +: 2]) // R08 R09
                    : s_r.mbase[c];                                // R07
                // Half point counted in issued transfers
                ev_h = (s_r.reload[c][15:1] != 15'h0)
                    && (16'(s_r.reload[c] - nc) == {1'b0, s_r.reload[c][15:1]}); // R18
                if (nc == 16'h0) begin
                    ev_f = 1'b1;
                    // Circular channels rearm and keep running
                    if (s_r.ctl[c][CTL_CIRC]) begin               // R10 R11
                        s_nxt.cnt[c]  = s_r.reload[c];
                        s_nxt.pcur[c] = s_r.pbase[c];
                        s_nxt.mcur[c] = s_r.mbase[c];
                    end
                end
            end
            // Bus error stops the channel
            if (i_xfer_err && (i_xfer_err_chan == 3'(c))) begin
                ev_e = 1'b1;
                s_nxt.ctl[c][CTL_EN] = 1'b0;
            end
            // Flags: the set wins over a clear in the same cycle
            clr4 = 4'h0;
            if (i_reg_wr_en && (i_reg_addr == OFS_CLEAR)) begin
                clr4 = i_reg_wdata[c*4 +: 4];                     // R21
                if (clr4[FLG_G]) begin
                    clr4 = 4'hf;                                  // R22
                end
            end
            fl        = s_r.flg[c] & ~clr4;
            fl[FLG_F] = fl[FLG_F] | ev_f;                         // R16
            fl[FLG_H] = fl[FLG_H] | ev_h;
            fl[FLG_E] = fl[FLG_E] | ev_e;
            fl[FLG_G] = fl[FLG_G] | (|fl[FLG_E:FLG_F]);           // R20
            s_nxt.flg[c] = fl;
            // Handshake with the peripheral of this channel
            unique case (s_r.st[c])
                CH_IDLE: begin
                    if (hit) begin
                        s_nxt.st[c] = CH_ISSUED;
                    end
                end
                CH_ISSUED: begin
                    // Acknowledge only once the command went out
                    if (out_fire && (o_cmd_chan == 3'(c))) begin  // R02
                        s_nxt.st[c] = s_r.ctl[c][CTL_M2M] ? CH_IDLE : CH_ACK;
                    end
                end
                CH_ACK: begin
                    // Hold until the request drops
                    if (!req_ch[c]) begin                         // R03
                        s_nxt.st[c] = CH_IDLE;
                    end
                end
                default: begin
                    s_nxt.st[c] = CH_IDLE;
                end
            endcase
        end
    end

    // State register
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    // ==========================================
    // Outputs
    assign o_reg_rdata = s_r.rdata;

    always_comb begin
        for (int c = 0; c < NCH; c++) begin
            o_ack[c] = (s_r.st[c] == CH_ACK);
            // Event and enable bits share positions
            o_irq[c] = |(s_r.flg[c][FLG_E:FLG_F] & s_r.ctl[c][3:1]); // R17
        end
    end

    // ==========================================
    // Checks
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_sys_rst);

    logic [1:0] max_channel_priority_level;                // Best eligible priority

    always_comb begin
        max_channel_priority_level = CHANNEL_PRIORITY_LEVEL_LOW;
        for (int c = 0; c < NCH; c++) begin
            if (elig[c] && s_r.ctl[c][CTL_CHANNEL_PRIORITY_LEVEL +: 2] > max_channel_priority_level) begin
                max_channel_priority_level = s_r.ctl[c][CTL_CHANNEL_PRIORITY_LEVEL +: 2];
            end
        end
    end

    arb_top_channel_priority_level_a: assert property (push |-> win_channel_priority_level == max_channel_priority_level) // R04
        else $error("arbiter skipped a higher priority channel");

    for (genvar g = 0; g < NCH; g++) begin : g_chk
        ack_after_issue_a: assert property ($rose(o_ack[g]) |->       // R02
            $past(out_fire && o_cmd_chan == 3'(g)))
            else $error("acknowledge without issued command");
        ack_holds_a: assert property (o_ack[g] && req_ch[g] |=> o_ack[g]) // R03
            else $error("acknowledge dropped under live request");
        irq_on_full_a: assert property ($rose(s_r.flg[g][FLG_F])     // R17
            && s_r.ctl[g][1] |-> o_irq[g])
            else $error("enabled full event gave no interrupt");
        summary_flag_a: assert property (|s_r.flg[g][FLG_E:FLG_F] |-> s_r.flg[g][FLG_G]) // R20
            else $error("summary flag missing");
        zero_no_issue_a: assert property (push && win_ch == 3'(g) |-> // R13
            s_r.cnt[g] != 16'h0 && s_r.ctl[g][CTL_EN])
            else $error("issue with zero count or disabled");
        locked_fields_a: assert property (s_r.ctl[g][CTL_EN]         // R27
            && $past(s_r.ctl[g][CTL_EN]) |-> $stable(s_r.ctl[g][14:4]))
            else $error("locked field changed while enabled");
        count_step_a: assert property (push && win_ch == 3'(g)       // R13
            && s_r.cnt[g] != 16'h1 |=> s_r.cnt[g] == $past(s_r.cnt[g]) - 16'h1)
            else $error("count did not step by one");
        circ_reload_a: assert property (push && win_ch == 3'(g)      // R10
            && s_r.cnt[g] == 16'h1 && s_r.ctl[g][CTL_CIRC]
            |=> s_r.cnt[g] == s_r.reload[g] && s_r.flg[g][FLG_F])
            else $error("circular reload or full flag missing");
    end

    circ_wrap_c: cover property (push && s_r.ctl[win_ch][CTL_CIRC]
        && s_r.cnt[win_ch] == 16'h1);
    m2m_issue_c: cover property (push && s_r.ctl[win_ch][CTL_M2M]);
    stall_c: cover property (found && !buf_in_ready);

endmodule : fcd_top

`default_nettype wire

/* File: fcd_top_tb.sv */
// Self-checking bench for the transfer controller
`default_nettype none

module fcd_top_tb
    import fcd_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic           i_clk, i_sys_rst, wr_en, rd_en, cmd_rdy, xerr;
    logic [7:0]     addr;
    logic [31:0]    wdata, rdata, paddr, maddr;
    logic [2:0]     echan, chan;
    logic [NCH-1:0] want, preq, ack, irq;
    logic [NRMP-1:0] rmp_req, rmp_cfg;
    logic           cvalid, cdir;
    logic [1:0]     pw, mw;
    int             fails = 0;
    int             check_count = 0;

    fcd_top DUT (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_reg_addr(addr), .i_reg_wr_en(wr_en),
        .i_reg_wdata(wdata), .i_reg_rd_en(rd_en), .o_reg_rdata(rdata), .i_req_fixed(preq),
        .i_req_remap(rmp_req), .i_system_remap_config(rmp_cfg), .o_ack(ack), .o_cmd_valid(cvalid),
        .i_cmd_ready(cmd_rdy), .o_cmd_chan(chan), .o_cmd_dir(cdir), .o_cmd_peripheral_data_width(pw),
        .o_cmd_memory_data_width(mw), .o_cmd_paddr(paddr), .o_cmd_maddr(maddr), .i_xfer_err(xerr),
        .i_xfer_err_chan(echan), .o_irq(irq));
    fcd_periph PER (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_want(want), .i_ack(ack), .o_req(preq));

    // ==========================================
    // Clock, 8 ns period
    initial begin
        i_clk = 1'b0;
        forever #4 i_clk = ~i_clk;
    end

    // ==========================================
    // Shared tasks
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            fails++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge i_clk);
        addr  <= a;
        wdata <= d;
        wr_en <= 1'b1;
        @(posedge i_clk);
        wr_en <= 1'b0;
    endtask : wr

    // Read data lands one cycle after the strobe edge
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        @(posedge i_clk);
        addr  <= a;
        rd_en <= 1'b1;
        @(posedge i_clk);
        rd_en <= 1'b0;
        @(negedge i_clk);
        chk(rdata, exp);
    endtask : rd

    // Wait for a command, compare it, then take it with a one-cycle ready
    task automatic pop(input logic [2:0] c, input logic [31:0] pa, input logic [31:0] ma, input logic [4:0] f);
        for (int i = 0; i < 60 && cvalid !== 1'b1; i++) @(negedge i_clk);
        chk({31'h0, cvalid}, 32'h1);
        chk({29'h0, chan}, {29'h0, c});
        chk(paddr, pa);
        chk(maddr, ma);
        chk({27'h0, cdir, pw, mw}, {27'h0, f});
        @(posedge i_clk);
        cmd_rdy <= 1'b1;
        @(posedge i_clk);
        cmd_rdy <= 1'b0;
        repeat (6) @(posedge i_clk);
    endtask : pop

    task automatic finish_test;
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : finish_test

    // ==========================================
    // Watchdog, far beyond the few hundred cycles the tests need
    initial begin
        #200000;
        fails++;
        finish_test();
    end

    // ==========================================
    // Main sequence
    initial begin
        {i_sys_rst, wr_en, rd_en, cmd_rdy, xerr} = 5'h10;
        {addr, wdata, echan, want, rmp_req, rmp_cfg} = '0;
        repeat (16) @(posedge i_clk);
        i_sys_rst <= 1'b0;
        rd(8'h00, 32'h0);
        rd(8'h08, 32'h0);
        rd(8'hfc, 32'h0);
        // Ch1 high priority, peripheral increment, 16-bit, full irq on
        wr(8'h1c, 32'h0000_2142);
        wr(8'h24, 32'h0000_0100);
        wr(8'h20, 32'h0000_0002);
        wr(8'h0c, 32'h0000_0002);
        wr(8'h10, 32'h0000_0040);
        wr(8'h08, 32'h0000_0001);
        wr(8'h1c, 32'h0000_2143);
        want <= 5'h03;
        repeat (8) @(posedge i_clk);                     // Both pending, datapath stalled
        pop(3'h1, 32'h0000_0100, 32'h0, 5'h04);
        pop(3'h0, 32'h0000_0040, 32'h0, 5'h00);
        pop(3'h1, 32'h0000_0102, 32'h0, 5'h04);
        pop(3'h0, 32'h0000_0040, 32'h0, 5'h00);
        want <= 5'h00;
        @(negedge i_clk);
        chk({31'h0, cvalid}, 32'h0);
        rd(8'h00, 32'h0000_0077);
        chk({27'h0, irq}, 32'h0000_0002);
        wr(8'h04, 32'h0000_0002);
        rd(8'h00, 32'h0000_0075);
        wr(8'h04, 32'h0000_0010);
        rd(8'h00, 32'h0000_0005);
        chk({27'h0, irq}, 32'h0);
        @(posedge i_clk);
        xerr  <= 1'b1;
        echan <= 3'h2;
        @(posedge i_clk);
        xerr  <= 1'b0;
        rd(8'h00, 32'h0000_0905);
        // Ch3 memory mode, one item, no request
        wr(8'h48, 32'h0000_0001);
        wr(8'h4c, 32'h0000_0200);
        wr(8'h44, 32'h0000_4001);
        pop(3'h3, 32'h0000_0200, 32'h0, 5'h00);
        wr(8'h44, 32'h0000_3001);
        rd(8'h44, 32'h0000_4001);
        // Ch2 circular, fed by the remapped source, 32-bit memory side
        rd(8'h30, 32'h0);
        wr(8'h34, 32'h0000_0001);
        wr(8'h38, 32'h0000_0300);
        wr(8'h3c, 32'h0000_0400);
        wr(8'h30, 32'h0000_0831);
        rmp_cfg <= 2'h2;
        rmp_req <= 2'h2;
        pop(3'h2, 32'h0000_0300, 32'h0000_0400, 5'h12);
        @(negedge i_clk);
        chk({27'h0, ack}, 32'h0000_0004);
        @(posedge i_clk);
        rmp_req <= 2'h0;
        rd(8'h34, 32'h0000_0001);
        chk({27'h0, ack}, 32'h0);
        @(posedge i_clk);
        rmp_req <= 2'h2;
        pop(3'h2, 32'h0000_0300, 32'h0000_0400, 5'h12);
        rmp_req <= 2'h0;
        finish_test();
    end
endmodule : fcd_top_tb

`default_nettype wire
